// >>> src/sbsr_pkg.sv
// Notes on behaviour
// - Enabled status bits raise summary and request
// - Query shows summary, poll shows request
// - Status bits seven, three, two read zero
// - Request clears on poll; summary follows condition
// - Bit five summarises masked event register
// - Bit four: response ready until terminator sent
// - Bit one summarises masked trip register
// - Bit zero summarises masked state register
// - Poll bit is OR of masked status
// - Poll bit readable by its own query
// - Poll line and sense configured and released
// - Poll drives lines low only, never high
// - Talk with nothing to say: code 3
// - Queue full with pending response: code 2
// - Terminator or extra END pending: code 1
// - Power-on: masks, codes zero; events 128
// - Trip and state reflect conditions after reset
// - Clear-on-read registers also cleared by clear
// - Request and poll masks written and read
// - Event bit two flags query errors
// - Masks take any byte, read back
package sbsr_pkg;
  localparam int SBSR_W = 8;
  // Status byte positions
  localparam int SSB_STATE = 0;
  localparam int SSB_TRIP = 1;
  localparam int SSB_MAV = 4;
  localparam int SSB_ESB = 5;
  localparam int SSB_RQS = 6;
  // Event register positions
  localparam int ESR_OPC = 0;
  localparam int ESR_QRY = 2;
  localparam int ESR_EXE = 4;
  localparam int ESR_CMD = 5;
  localparam int ESR_PON = 7;
  localparam logic [7:0] ESR_USED = 8'hB5;
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Query error codes
  localparam logic [7:0] QE_INTERRUPTED = 8'h01;
  localparam logic [7:0] QE_DEADLOCK = 8'h02;
  localparam logic [7:0] QE_UNTERMINATED = 8'h03;
  // Poll configuration byte fields
  localparam int PPE_SENSE = 3;
  localparam int PPE_LINE_HI = 2;
  typedef enum logic [4:0] {
    SBSR_SRE_SET = 5'h00, SBSR_SRE_Q = 5'h01,
    SBSR_PRE_SET = 5'h02, SBSR_PRE_Q = 5'h03,
    SBSR_ESE_SET = 5'h04, SBSR_ESE_Q = 5'h05,
    SBSR_SMASK_SET = 5'h06, SBSR_SMASK_Q = 5'h07,
    SBSR_TMASK_SET = 5'h08, SBSR_TMASK_Q = 5'h09,
    SBSR_TRIP_Q = 5'h0A, SBSR_STATE_Q = 5'h0B,
    SBSR_EXEC_Q = 5'h0C, SBSR_QERR_Q = 5'h0D,
    SBSR_ESR_Q = 5'h0E, SBSR_SSB_Q = 5'h0F,
    SBSR_IST_Q = 5'h10, SBSR_CLS = 5'h11,
    SBSR_PPC = 5'h12, SBSR_PPE = 5'h13,
    SBSR_PPD = 5'h14, SBSR_PPU = 5'h15
  } sbsr_cmd_t;
  typedef enum logic [1:0] {
    SBSR_PP_IDLE = 2'b01,
    SBSR_PP_ARMED = 2'b10
  } sbsr_pp_t;
endpackage

// >>> src/sbsr_top.sv
`timescale 1ns/1ns
module sbsr_top import sbsr_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire sbsr_cmd_t cmd_code,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic spoll_req,
  output logic spoll_valid,
  output logic [7:0] spoll_data,
  output logic srq,
  input wire logic ppoll,
  output logic [7:0] dio_out,
  output logic [7:0] dio_oe,
  input wire logic [7:0] trip_cond,
  input wire logic [7:0] state_cond,
  input wire logic opc_event,
  input wire logic cmd_err_event,
  input wire logic exec_err_valid,
  input wire logic [7:0] exec_err_in,
  input wire logic msg_ready,
  input wire logic rmt_sent,
  input wire logic talk_addr,
  input wire logic formatter_idle,
  input wire logic queue_empty,
  input wire logic queue_full,
  input wire logic resp_waiting,
  input wire logic term_parsed,
  input wire logic multi_end,
  output logic parser_reset,
  output logic formatter_reset
);
  // ==========================================
  // Registers
  logic [7:0] srq_mask;
  logic [7:0] pp_mask;
  logic [7:0] event_mask;
  logic [7:0] input_state_mask;
  logic [7:0] input_trip_mask;
  logic [7:0] input_trip_register;
  logic [7:0] event_reg;
  logic [7:0] execution_error_code;
  logic [7:0] query_protocol_error_code;
  logic mav;
  logic rqs;
  logic mss_q;
  logic [7:0] status_summary_byte;
  logic mss;
  logic ist;
  sbsr_pp_t pp_state;
  logic pp_enabled;
  logic pp_sense;
  logic [2:0] pp_line;

  wire logic wr = cmd_valid;
  wire logic clr = cmd_valid && cmd_code == SBSR_CLS;
  wire logic rd_trip = cmd_valid && cmd_code == SBSR_TRIP_Q;
  wire logic rd_esr = cmd_valid && cmd_code == SBSR_ESR_Q;
  wire logic rd_exec = cmd_valid && cmd_code == SBSR_EXEC_Q;
  wire logic rd_qerr = cmd_valid && cmd_code == SBSR_QERR_Q;

  // ==========================================
  // Query protocol errors
  wire logic qe_unterm = talk_addr && formatter_idle && queue_empty;
  wire logic qe_dead = queue_full && resp_waiting;
  wire logic qe_trip_summary_bit = (term_parsed || multi_end) && resp_waiting;
  wire logic qe_any = qe_unterm || qe_dead || qe_trip_summary_bit;

  // ==========================================
  // Summaries, all combinational; state bit from the live state_cond
  logic trip_sum;
  logic state_sum;
  logic esb;
  always_comb begin
    trip_sum = |(input_trip_register & input_trip_mask);
    state_sum = |(state_cond & input_state_mask);
    esb = |(event_reg & event_mask);
    status_summary_byte = ZERO8;
    status_summary_byte[SSB_STATE] = state_sum;
    status_summary_byte[SSB_TRIP] = trip_sum;
    status_summary_byte[SSB_MAV] = mav;
    status_summary_byte[SSB_ESB] = esb;
    // Bit six excluded from its own summary to avoid a loop
    mss = |(status_summary_byte & srq_mask);
    ist = |(status_summary_byte & pp_mask) || (mss && pp_mask[SSB_RQS]);
  end

  // ==========================================
  // Mask registers
  always_ff @(posedge clk) begin
    if (rst) begin
      srq_mask <= ZERO8;
      pp_mask <= ZERO8;
      event_mask <= ZERO8;
      input_state_mask <= ZERO8;
      input_trip_mask <= ZERO8;
    end else if (wr) begin
      case (cmd_code)
        SBSR_SRE_SET: srq_mask <= cmd_data;
        SBSR_PRE_SET: pp_mask <= cmd_data;
        SBSR_ESE_SET: event_mask <= cmd_data;
        SBSR_SMASK_SET: input_state_mask <= cmd_data;
        SBSR_TMASK_SET: input_trip_mask <= cmd_data;
        default: ;
      endcase
    end
  end

  // ==========================================
  // Trip register: sticky, reload live conditions on clear
  always_ff @(posedge clk) begin
    if (rst) begin
      input_trip_register <= ZERO8;
    end else if (rd_trip || clr) begin
      input_trip_register <= trip_cond;
    end else begin
      input_trip_register <= input_trip_register | trip_cond;
    end
  end

  // ==========================================
  // Event register; a new event wins over a clear
  logic [7:0] ev_set;
  always_comb begin
    ev_set = ZERO8;
    ev_set[ESR_OPC] = opc_event;
    ev_set[ESR_QRY] = qe_any;
    ev_set[ESR_EXE] = exec_err_valid && (exec_err_in != ZERO8);
    ev_set[ESR_CMD] = cmd_err_event;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      event_reg <= ESR_RESET;
    end else if (rd_esr || clr) begin
      event_reg <= ev_set;
    end else begin
      event_reg <= (event_reg | ev_set) & ESR_USED;
    end
  end

  // ==========================================
  // Execution error code
  always_ff @(posedge clk) begin
    if (rst) begin
      execution_error_code <= ZERO8;
    end else if (exec_err_valid && exec_err_in != ZERO8) begin
      execution_error_code <= exec_err_in;
    end else if (rd_exec || clr) begin
      execution_error_code <= ZERO8;
    end
  end

  // ==========================================
  // Query error code; unterminated outranks deadlock
  always_ff @(posedge clk) begin
    if (rst) begin
      query_protocol_error_code <= ZERO8;
    end else if (qe_unterm) begin
      query_protocol_error_code <= QE_UNTERMINATED;
    end else if (qe_dead) begin
      query_protocol_error_code <= QE_DEADLOCK;
    end else if (qe_trip_summary_bit) begin
      query_protocol_error_code <= QE_INTERRUPTED;
    end else if (rd_qerr || clr) begin
      query_protocol_error_code <= ZERO8;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      parser_reset <= 1'b0;
      formatter_reset <= 1'b0;
    end else begin
      parser_reset <= qe_unterm;
      formatter_reset <= qe_dead || qe_trip_summary_bit;
    end
  end

  // ==========================================
  // Message available
  always_ff @(posedge clk) begin
    if (rst) begin
      mav <= 1'b0;
    end else if (msg_ready) begin
      mav <= 1'b1;
    end else if (rmt_sent || qe_dead || qe_trip_summary_bit) begin
      mav <= 1'b0;
    end
  end

  // ==========================================
  // Request service: set on a new summary, cleared by poll
  always_ff @(posedge clk) begin
    if (rst) begin
      mss_q <= 1'b0;
      rqs <= 1'b0;
    end else begin
      mss_q <= mss;
      if (mss && !mss_q) begin
        rqs <= 1'b1;
      end else if (spoll_req) begin
        rqs <= 1'b0;
      end
    end
  end
  assign srq = rqs;

  always_ff @(posedge clk) begin
    if (rst) begin
      spoll_valid <= 1'b0;
      spoll_data <= ZERO8;
    end else begin
      spoll_valid <= spoll_req;
      if (spoll_req) begin
        spoll_data <= status_summary_byte;
        spoll_data[SSB_RQS] <= rqs;
      end
    end
  end

  // ==========================================
  // Query answers, one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= ZERO8;
    end else begin
      rsp_valid <= 1'b0;
      if (cmd_valid) begin
        rsp_valid <= 1'b1;
        case (cmd_code)
          SBSR_SRE_Q: rsp_data <= srq_mask;
          SBSR_PRE_Q: rsp_data <= pp_mask;
          SBSR_ESE_Q: rsp_data <= event_mask;
          SBSR_SMASK_Q: rsp_data <= input_state_mask;
          SBSR_TMASK_Q: rsp_data <= input_trip_mask;
          SBSR_TRIP_Q: rsp_data <= input_trip_register;
          SBSR_STATE_Q: rsp_data <= state_cond;
          SBSR_EXEC_Q: rsp_data <= execution_error_code;
          SBSR_QERR_Q: rsp_data <= query_protocol_error_code;
          SBSR_ESR_Q: rsp_data <= event_reg;
          SBSR_SSB_Q: begin
            rsp_data <= status_summary_byte;
            rsp_data[SSB_RQS] <= mss;
          end
          SBSR_IST_Q: rsp_data <= {7'h00, ist};
          default: rsp_valid <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================
  // Parallel poll configuration; enable only after configure
  always_ff @(posedge clk) begin
    if (rst) begin
      pp_state <= SBSR_PP_IDLE;
      pp_enabled <= 1'b0;
      pp_sense <= 1'b0;
      pp_line <= 3'h0;
    end else if (cmd_valid) begin
      if (cmd_code == SBSR_PPU) begin
        pp_enabled <= 1'b0;
        pp_state <= SBSR_PP_IDLE;
      end else begin
        case (pp_state)
          SBSR_PP_IDLE: begin
            if (cmd_code == SBSR_PPC) begin
              pp_state <= SBSR_PP_ARMED;
            end
          end
          SBSR_PP_ARMED: begin
            if (cmd_code == SBSR_PPE) begin
              pp_enabled <= 1'b1;
              pp_sense <= cmd_data[PPE_SENSE];
              pp_line <= cmd_data[PPE_LINE_HI:0];
            end else if (cmd_code == SBSR_PPD) begin
              pp_enabled <= 1'b0;
            end else if (cmd_code != SBSR_PPC) begin
              pp_state <= SBSR_PP_IDLE;
            end
          end
          default: pp_state <= SBSR_PP_IDLE;
        endcase
      end
    end
  end

  // Asserted (low) level is driven, the high level is left to the pull-up
  logic pp_drive;
  always_comb begin
    pp_drive = ppoll && pp_enabled && (ist == pp_sense);
    dio_out = ZERO8;
    dio_oe = ZERO8;
    dio_oe[pp_line] = pp_drive;
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_poll;
    rqs && spoll_req;
  endsequence
  sequence s_cleared;
    !rqs && spoll_valid && spoll_data[SSB_RQS];
  endsequence

  a_reserved_zero: assert property (
    status_summary_byte[7] == 1'b0 && status_summary_byte[3:2] == 2'b00)
    else $error("reserved status bits not zero");
  a_poll_clears: assert property (
    (s_poll and !(mss && !mss_q)) |=> s_cleared)
    else $error("serial poll did not clear request");
  a_rqs_raise: assert property (
    mss && !mss_q |=> rqs)
    else $error("request not raised on new summary");
  a_sbyte_query: assert property (
    cmd_valid && cmd_code == SBSR_SSB_Q |=> rsp_valid
    && rsp_data[SSB_RQS] == $past(mss))
    else $error("status query wrong summary bit");
  a_mav_clear: assert property (
    rmt_sent && !msg_ready |=> !status_summary_byte[SSB_MAV])
    else $error("message bit not cleared");
  a_ist_query: assert property (
    cmd_valid && cmd_code == SBSR_IST_Q |=> rsp_data == {7'h00, $past(ist)})
    else $error("ist query wrong");
  a_unterm_code: assert property (
    qe_unterm |=> query_protocol_error_code == QE_UNTERMINATED
    && parser_reset && event_reg[ESR_QRY])
    else $error("unterminated error not recorded");
  a_dead_code: assert property (
    qe_dead && !qe_unterm |=> query_protocol_error_code == QE_DEADLOCK
    && formatter_reset && !mav)
    else $error("deadlock error not recorded");
  a_trip_summary_bit_code: assert property (
    qe_trip_summary_bit && !qe_unterm && !qe_dead |=>
    query_protocol_error_code == QE_INTERRUPTED && formatter_reset)
    else $error("interrupted error not recorded");
  a_pp_passive: assert property (
    (dio_out == ZERO8 && $onehot0(dio_oe))
    and (!ppoll |-> dio_oe == ZERO8))
    else $error("poll drives high or outside poll");
  a_mask_back: assert property (
    cmd_valid && cmd_code == SBSR_SRE_SET ##1 !cmd_valid ##1
    cmd_valid && cmd_code == SBSR_SRE_Q |=> rsp_data == $past(cmd_data, 3))
    else $error("mask read back wrong");
endmodule

// >>> tb/sbsr_gpib_ctrl.sv
`timescale 1ns/1ns
// ==========================================================
// Controller side: serial and parallel polls, pulled-up lines
module sbsr_gpib_ctrl (
  input wire logic clk,
  input wire logic spoll_valid,
  input wire logic [7:0] spoll_data,
  input wire logic [7:0] dio_out,
  input wire logic [7:0] dio_oe,
  output logic spoll_req,
  output logic ppoll,
  output logic [7:0] dio
);
  // Undriven lines float up to the pull-up level
  assign dio = (dio_oe & dio_out) | ~dio_oe;
  initial begin
    spoll_req = 1'b0;
    ppoll = 1'b0;
  end
  task automatic serial_poll(output logic [7:0] sb);
    @(negedge clk);
    spoll_req = 1'b1;
    @(negedge clk);
    // Answer strobe stands only in the cycle after the request
    sb = spoll_valid ? spoll_data : 8'hXX;
    spoll_req = 1'b0;
  endtask
  task automatic par_poll(output logic [7:0] lv);
    @(negedge clk);
    ppoll = 1'b1;
    @(negedge clk);
    lv = dio;
    ppoll = 1'b0;
  endtask
endmodule

// >>> tb/test_status_byte_service_request.sv
`timescale 1ns/1ns
module test_status_byte_service_request import sbsr_pkg::*;;
  logic clk, rst, cmd_valid, rsp_valid, spoll_req, spoll_valid, srq;
  logic ppoll, opc_event, cmd_err_event, exec_err_valid, msg_ready;
  logic rmt_sent, talk_addr, formatter_idle, queue_empty, queue_full;
  logic resp_waiting, term_parsed, multi_end, parser_reset;
  logic formatter_reset, m_mav;
  sbsr_cmd_t cmd_code;
  logic [7:0] cmd_data, rsp_data, spoll_data, dio_out, dio_oe, dio;
  logic [7:0] trip_cond, state_cond, exec_err_in, got, d;
  logic [7:0] m_mask [5];
  logic [7:0] m_esr, m_trip, m_exec;
  logic [2:0] ln;
  int n_mismatch, samples_checked, cycles;
  sbsr_cmd_t zq [$] = '{SBSR_SRE_Q, SBSR_PRE_Q, SBSR_ESE_Q, SBSR_SMASK_Q,
    SBSR_TMASK_Q, SBSR_EXEC_Q, SBSR_QERR_Q, SBSR_ESR_Q, SBSR_TRIP_Q};

  sbsr_top DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .spoll_req(spoll_req), .spoll_valid(spoll_valid),
    .spoll_data(spoll_data), .srq(srq), .ppoll(ppoll), .dio_out(dio_out),
    .dio_oe(dio_oe), .trip_cond(trip_cond), .state_cond(state_cond),
    .opc_event(opc_event), .cmd_err_event(cmd_err_event),
    .exec_err_valid(exec_err_valid), .exec_err_in(exec_err_in),
    .msg_ready(msg_ready), .rmt_sent(rmt_sent), .talk_addr(talk_addr),
    .formatter_idle(formatter_idle), .queue_empty(queue_empty),
    .queue_full(queue_full), .resp_waiting(resp_waiting),
    .term_parsed(term_parsed), .multi_end(multi_end),
    .parser_reset(parser_reset), .formatter_reset(formatter_reset));
  sbsr_gpib_ctrl ctrl (.clk(clk), .spoll_valid(spoll_valid),
    .spoll_data(spoll_data), .dio_out(dio_out), .dio_oe(dio_oe),
    .spoll_req(spoll_req), .ppoll(ppoll), .dio(dio));

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Reference model and bus tasks
  function automatic logic [7:0] m_stb();
    logic [7:0] s;
    s = 8'h00;
    s[0] = |(state_cond & m_mask[3]);
    s[1] = |(m_trip & m_mask[4]);
    s[4] = m_mav;
    s[5] = |(m_esr & m_mask[2]);
    s[6] = |(s & m_mask[0]);
    return s;
  endfunction
  task automatic check(input string w, input logic [7:0] e,
                       input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", w, e, g);
    end
  endtask
  task automatic send(input sbsr_cmd_t c, input logic [7:0] v);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = v;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic query(input sbsr_cmd_t c, input logic [7:0] e);
    send(c, 8'h00);
    // Answer strobe stands only in the cycle after the command
    check(c.name(), e, rsp_valid ? rsp_data : 8'hXX);
    if (c == SBSR_ESR_Q) m_esr = 8'h00;
    if (c == SBSR_EXEC_Q) m_exec = 8'h00;
    if (c == SBSR_TRIP_Q) m_trip = 8'h00;
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hE698));
    {cmd_valid, opc_event, cmd_err_event, exec_err_valid, msg_ready} = '0;
    {rmt_sent, talk_addr, formatter_idle, queue_empty, queue_full} = '0;
    {resp_waiting, term_parsed, multi_end, m_mav} = '0;
    {cmd_data, trip_cond, exec_err_in, m_trip, m_exec} = '0;
    cmd_code = SBSR_SSB_Q;
    state_cond = 8'($urandom);
    m_esr = ESR_RESET;
    for (int i = 0; i < 5; i++) m_mask[i] = 8'h00;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    query(SBSR_STATE_Q, state_cond);
    query(SBSR_SSB_Q, 8'h00);
    query(SBSR_ESR_Q, 8'h80);
    foreach (zq[i]) query(zq[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      send(sbsr_cmd_t'(5'(2 * i)), d);
      m_mask[i] = d;
      query(sbsr_cmd_t'(5'(2 * i + 1)), d);
    end
    trip_cond = 8'($urandom);
    repeat (2) @(negedge clk);
    m_trip = trip_cond;
    trip_cond = 8'h00;
    query(SBSR_SSB_Q, m_stb());
    query(SBSR_TRIP_Q, m_trip);
    query(SBSR_TRIP_Q, 8'h00);
    // Known masks, then flush any stale request by one poll
    state_cond = 8'h00;
    send(SBSR_SRE_SET, 8'h01);
    send(SBSR_SMASK_SET, 8'h01);
    m_mask[0] = 8'h01;
    m_mask[3] = 8'h01;
    ctrl.serial_poll(got);
    state_cond = 8'h01;
    repeat (2) @(negedge clk);
    check("srq", 8'h01, {7'h00, srq});
    ctrl.serial_poll(got);
    check("poll", m_stb(), got);
    ctrl.serial_poll(got);
    check("poll", m_stb() & 8'hBF, got);
    query(SBSR_SSB_Q, m_stb());
    send(SBSR_ESE_SET, 8'h20);
    m_mask[2] = 8'h20;
    @(negedge clk);
    {opc_event, cmd_err_event, exec_err_valid} = '1;
    exec_err_in = 8'h66;
    @(negedge clk);
    {opc_event, cmd_err_event, exec_err_valid} = '0;
    m_esr = 8'h31;
    m_exec = 8'h66;
    query(SBSR_SSB_Q, m_stb());
    query(SBSR_EXEC_Q, m_exec);
    query(SBSR_ESR_Q, m_esr);
    msg_ready = 1'b1;
    @(negedge clk);
    msg_ready = 1'b0;
    m_mav = 1'b1;
    query(SBSR_SSB_Q, m_stb());
    rmt_sent = 1'b1;
    @(negedge clk);
    rmt_sent = 1'b0;
    m_mav = 1'b0;
    query(SBSR_SSB_Q, m_stb());
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      {talk_addr, formatter_idle, queue_empty} = {3{k == 3}};
      queue_full = (k == 2);
      resp_waiting = (k < 3);
      term_parsed = (k == 1);
      multi_end = (k == 0);
      @(negedge clk);
      {talk_addr, formatter_idle, queue_empty, queue_full} = '0;
      {resp_waiting, term_parsed, multi_end} = '0;
      // Reset pulses stand for one cycle only
      check("parser_reset", {7'h00, k == 3}, {7'h00, parser_reset});
      check("formatter_reset", {7'h00, k < 3},
            {7'h00, formatter_reset});
      m_esr = m_esr | 8'h04;
      query(SBSR_QERR_Q, (k == 3) ? 8'h03 : (k == 2) ? 8'h02 : 8'h01);
      query(SBSR_ESR_Q, m_esr);
    end
    // Leave an event pending so the clear has something to remove
    opc_event = 1'b1;
    @(negedge clk);
    opc_event = 1'b0;
    send(SBSR_CLS, 8'h00);
    query(SBSR_ESR_Q, 8'h00);
    send(SBSR_PRE_SET, 8'h01);
    query(SBSR_IST_Q, 8'h01);
    for (int s = 0; s < 2; s++) begin
      ln = 3'($urandom);
      send(SBSR_PPC, 8'h00);
      send(SBSR_PPE, {4'h0, s[0], ln});
      ctrl.par_poll(got);
      check("dio", (s == 1) ? ~(8'h01 << ln) : 8'hFF, got);
    end
    send(SBSR_PPC, 8'h00);
    send(SBSR_PPD, 8'h00);
    ctrl.par_poll(got);
    check("dio", 8'hFF, got);
    send(SBSR_PPC, 8'h00);
    send(SBSR_PPE, {5'h01, ln});
    send(SBSR_PPU, 8'h00);
    ctrl.par_poll(got);
    check("dio", 8'hFF, got);
    report_and_stop();
  end
endmodule
